// ---- bench/fps_flash_model.sv ----
// behavioural nor flash device model
`timescale 1ns/1ns
`default_nettype none
module fps_flash_model (
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire [19:0] i_addr,
  input wire [15:0] i_dq,
  input wire i_lock,
  input wire i_fail,
  input wire i_vpp_low,
  output wire [15:0] o_dq
);
  reg [7:0] sr = 8'h80;
  reg [15:0] mem [0:15];
  reg [15:0] drv = 16'h0;
  reg [15:0] last = 16'h0;
  reg [15:0] pd = 16'h0;
  reg [3:0] pa = 4'h0;
  reg [1:0] pend = 2'd0;
  reg stat = 1'b0;
  reg ers = 1'b0;
  reg halt = 1'b0;
  reg go = 1'b0;
  integer left = 0;
  integer k;
  initial for (k = 0; k < 16; k++) mem[k] = 16'hFFFF;
  // ========================================
  // command decode
  always @(posedge i_we_n)
  if (!i_ce_n)
  begin
    if (pend == 2'd1)
    begin
      pend = 2'd0;
      ers = 1'b0;
      pa = i_addr[3:0];
      pd = i_dq;
      if (i_vpp_low || sr[3]) sr[3] = 1'b1;
      else if (i_lock) sr[1] = 1'b1;
      else go = 1'b1;
    end
    else if (pend == 2'd2)
    begin
      pend = 2'd0;
      ers = 1'b1;
      if (i_dq[7:0] != 8'hD0 || sr[6]) sr[5:4] = 2'b11;
      else if (sr[3] | sr[1]) go = 1'b0;
      else if (i_lock) sr[1] = 1'b1;
      else go = 1'b1;
    end
    else
      case (i_dq[7:0])
        8'h40: pend = 2'd1;
        8'h20: pend = 2'd2;
        8'h70: stat = 1'b1;
        8'hFF: stat = 1'b0;
        8'h50: {sr[5:3], sr[1]} = 4'h0;
        8'hB0: halt = !sr[7];
        8'hD0: go = sr[2] | sr[6];
        default: sr[5:4] = 2'b11;
      endcase
    if (go)
    begin
      go = 1'b0;
      sr[7] = 1'b0;
      sr[6] = 1'b0;
      sr[2] = 1'b0;
      left = 2000;
      stat = 1'b1;
    end
  end
  // ========================================
  // write engine
  always #100
  begin
    if (!sr[7] && halt)
    begin
      halt = 1'b0;
      sr[7] = 1'b1;
      sr[ers ? 6 : 2] = 1'b1;
    end
    else if (!sr[7] && left <= 100)
    begin
      sr[7] = 1'b1;
      if (i_fail) sr[ers ? 5 : 4] = 1'b1;
      else if (ers) for (k = 0; k < 16; k++) mem[k] = 16'hFFFF;
      else mem[pa] = pd;
    end
    else if (!sr[7]) left = left - 100;
  end
  // ========================================
  // read path, status refreshed on each read strobe
  always @(negedge i_oe_n) drv = (stat || !sr[7]) ? {~sr, sr} : mem[i_addr[3:0]];
  always @(posedge i_oe_n) last = drv;
  assign o_dq = (!i_ce_n && !i_oe_n) ? drv : ~last;
endmodule
`default_nettype wire

// ---- bench/fps_host_assertions.sv ----
// pin-level checks on the flash host controller
`timescale 1ns/1ns
`default_nettype none
module fps_chk (
  input wire i_core_clk,
  input wire i_rstn,
  input wire [3:0] i_addr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_ce_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire [19:0] o_flash_addr,
  input wire [15:0] o_dq_out,
  input wire o_dq_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ========================================
  // bus and pin relations
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data not idle");
  unmapped_zero_a: assert property (i_rd && i_addr > 4'h5 |=> o_rdata == 32'h0) else $error("unmapped read");
  strobe_excl_a: assert property (!(!o_we_n && !o_oe_n)) else $error("write and read strobes both low");
  write_pulse_a: assert property ($fell(o_we_n) |-> (!o_we_n) [*8] ##1 o_we_n)
    else $error("write pulse length");
  read_pulse_a: assert property ($fell(o_oe_n) |-> (!o_oe_n) [*8] ##1 o_oe_n)
    else $error("read pulse length");
  ce_gate_a: assert property (o_ce_n |-> o_we_n && o_oe_n) else $error("strobe without select");
  write_drive_a: assert property (!o_we_n |-> o_dq_oe && !o_ce_n) else $error("write without drive");
  read_release_a: assert property (!o_oe_n |-> !o_dq_oe) else $error("drive during read");
  write_stable_a: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_flash_addr) && $stable(o_dq_out))
    else $error("address or data moved in write");
  setup_gap_a: assert property ($fell(o_ce_n) |-> (o_we_n && o_oe_n) [*3] ##1 (!o_we_n || !o_oe_n))
    else $error("setup too short");
endmodule
bind fps_host fps_chk u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_flash_addr(o_flash_addr),
  .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
`default_nettype wire

// ---- bench/fps_host_tb_top.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.vh"
module fps_host_tb_top;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, lock = 0, fail = 0, vpp = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, v;
  logic [31:0] rdata;
  logic ce_n, oe_n, we_n, dq_oe;
  logic [19:0] faddr;
  logic [15:0] dq_out, m_dq, d;
  logic [7:0] s, e;
  integer bad_count = 0, n_tests = 0, k, n;
  wire [15:0] dq_w = dq_oe ? dq_out : m_dq;
  initial forever #5 clk = ~clk;
  fps_host u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_flash_addr(faddr), .o_dq_out(dq_out),
    .o_dq_oe(dq_oe), .i_dq_in(dq_w));
  fps_flash_model u_mem (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(faddr), .i_dq(dq_w),
    .i_lock(lock), .i_fail(fail), .i_vpp_low(vpp), .o_dq(m_dq));
  // ========================================
  // bus tasks
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] x);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] x);
    wr_reg(`FPS_REG_ADDR, {12'h0, a});
    wr_reg(`FPS_REG_WDATA, {16'h0, x});
    wr_reg(`FPS_REG_CTRL, {28'h0, c});
    v = 32'h1;
    for (n = 0; n < 200 && v[0] !== 1'b0; n++) rd_reg(`FPS_REG_STATUS);
    chk("host idle", {15'h0, v[0]}, 16'h0);
  endtask
  task automatic poll();
    for (k = 0; k < 60 && s[7] !== 1'b1 || k == 0; k++)
    begin
      op(`FPS_OP_READ_STATUS, 20'h0, 16'h0);
      rd_reg(`FPS_REG_FLASH_SR);
      s = v[7:0];
    end
    chk("poll ready", {15'h0, s[7]}, 16'h1);
  endtask
  task automatic rdarr(input logic [19:0] a);
    op(`FPS_OP_READ_ARRAY, 20'h0, 16'h0);
    op(`FPS_OP_READ, a, 16'h0);
    rd_reg(`FPS_REG_RDATA);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    n_tests++;
    if (seen !== ex)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // tests
  initial
  begin
    void'($urandom(32'h28b4));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`FPS_REG_FLASH_SR);
    chk("status reset", v[15:0], 16'h0080);
    rd_reg(4'hF);
    chk("unmapped", v[15:0], 16'h0);
    for (int i = 0; i < 2; i++)
    begin
      d = $urandom;
      op(`FPS_OP_PROGRAM, i * 5, d);
      poll();
      chk("ready", {15'h0, s[7]}, 16'h1);
      rdarr(i * 5);
      chk("word", v[15:0], d);
    end
    $display("test program done");
    for (int i = 0; i < 3; i++)
    begin
      {lock, fail, vpp} <= 3'b100 >> i;
      e = (i == 0) ? 8'h02 : (i == 1) ? 8'h10 : 8'h08;
      op(`FPS_OP_PROGRAM, 12 + i, 16'h1234);
      poll();
      chk("error flag", {8'h0, s & 8'h3E}, {8'h0, e});
      {lock, fail, vpp} <= 3'b000;
      d = $urandom;
      op(`FPS_OP_PROGRAM, 12 + i, d);
      poll();
      chk("sticky", {8'h0, s & e}, {8'h0, e});
      rdarr(12 + i);
      chk("retry", v[15:0], (i == 2) ? 16'hFFFF : d);
      op(`FPS_OP_CLEAR, 20'h0, 16'h0);
      poll();
      chk("cleared", {8'h0, s & 8'h3A}, 16'h0);
    end
    $display("test errors done");
    for (int i = 0; i < 2; i++)
    begin
      fail <= i[0];
      op(`FPS_OP_ERASE, 20'h3, 16'h0);
      poll();
      chk("erase flags", {14'h0, s[5:4]}, {14'h0, i[0], 1'b0});
    end
    fail <= 1'b0;
    op(`FPS_OP_CLEAR, 20'h0, 16'h0);
    rdarr(20'hC);
    chk("erased", v[15:0], 16'hFFFF);
    $display("test erase done");
    d = $urandom;
    op(`FPS_OP_PROGRAM, 20'h9, d);
    op(`FPS_OP_SUSPEND, 20'h0, 16'h0);
    poll();
    chk("prog susp", {8'h0, s & 8'h84}, 16'h0084);
    rd_reg(`FPS_REG_STATUS);
    chk("prog susp bit", {15'h0, v[5]}, 16'h1);
    rdarr(20'h2);
    chk("susp read", v[15:0], 16'hFFFF);
    op(`FPS_OP_RESUME, 20'h0, 16'h0);
    s = 8'h0;
    poll();
    rdarr(20'h9);
    chk("resumed", v[15:0], d);
    op(`FPS_OP_ERASE, 20'h0, 16'h0);
    op(`FPS_OP_SUSPEND, 20'h0, 16'h0);
    poll();
    chk("erase susp", {8'h0, s & 8'hC0}, 16'h00C0);
    op(`FPS_OP_ERASE, 20'h1, 16'h0);
    poll();
    chk("no erase", {8'h0, s & 8'hF0}, 16'h00C0);
    rd_reg(`FPS_REG_STATUS);
    chk("erase susp bit", {15'h0, v[6]}, 16'h1);
    op(`FPS_OP_RESUME, 20'h0, 16'h0);
    s = 8'h0;
    poll();
    chk("erase resumed", {8'h0, s & 8'hC0}, 16'h0080);
    $display("test suspend done");
    report_and_stop();
  end
  initial
  begin
    #600000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- rtl/fps_defines.vh ----
// constants for the parallel flash command sequencer (host side)
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH
// command codes on the data lines
`define FPS_CMD_PROG 8'h40
`define FPS_CMD_ERASE 8'h20
`define FPS_CMD_CONFIRM 8'hD0
`define FPS_CMD_SUSPEND 8'hB0
`define FPS_CMD_STATUS 8'h70
`define FPS_CMD_CLEAR 8'h50
`define FPS_CMD_READ 8'hFF
// status word bit positions
`define FPS_SR_READY 7
`define FPS_SR_ERS_SUSP 6
`define FPS_SR_ERS_FAIL 5
`define FPS_SR_PRG_FAIL 4
`define FPS_SR_SUPPLY 3
`define FPS_SR_PRG_SUSP 2
`define FPS_SR_LOCKED 1
// host register offsets
`define FPS_REG_CTRL 4'h0
`define FPS_REG_ADDR 4'h1
`define FPS_REG_WDATA 4'h2
`define FPS_REG_STATUS 4'h3
`define FPS_REG_RDATA 4'h4
`define FPS_REG_FLASH_SR 4'h5
// control operation codes written to ctrl register
`define FPS_OP_PROGRAM 4'h1
`define FPS_OP_ERASE 4'h2
`define FPS_OP_SUSPEND 4'h3
`define FPS_OP_RESUME 4'h4
`define FPS_OP_READ_ARRAY 4'h5
`define FPS_OP_READ_STATUS 4'h6
`define FPS_OP_CLEAR 4'h7
`define FPS_OP_READ 4'h8
// bus cycle timing in core clocks (10 ns each), each phase lasting one clock more than its value
`define FPS_T_SETUP 4'h2
`define FPS_T_STROBE 4'h7
`define FPS_T_HOLD 4'h2
`endif

// ---- rtl/fps_host.v ----
// host controller that drives a parallel nor flash through its pins
// What this block does
// - program: code 40, then data to target
// - after code 70 reads return status word
// - host may chain programs, polling ready
// - write FF to return to array read
// - error bits sticky until clear command
// - code B0 suspends program, bit two
// - FF reads during suspend, D0 resumes
// - erase: code 20, then D0 to sector
// - host may chain erases, polling ready
// - erase suspended allows FF or 40
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.vh"
module fps_host (
  input wire i_core_clk,
  input wire i_rstn,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg [19:0] o_flash_addr,
  output reg [15:0] o_dq_out,
  output reg o_dq_oe,
  input wire [15:0] i_dq_in
);
  // ==========================================================
  // bus cycle states
  localparam ST_IDLE = 3'h0;
  localparam ST_WSETUP = 3'h1;
  localparam ST_WSTROBE = 3'h2;
  localparam ST_WHOLD = 3'h3;
  localparam ST_RSETUP = 3'h4;
  localparam ST_RSTROBE = 3'h5;
  localparam ST_RHOLD = 3'h6;
  localparam ST_NEXT = 3'h7;

  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  reg [19:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [3:0] op_reg;
  reg [1:0] step_reg;
  reg [1:0] steps_reg;
  reg [15:0] rdata_reg;
  reg [7:0] flash_sr_reg;
  reg busy_reg;
  reg status_mode_reg;
  reg ers_susp_reg;
  reg prg_susp_reg;
  reg [15:0] dq_s1_reg;
  reg [15:0] dq_s2_reg;
  reg [7:0] cyc_data;
  reg cyc_read;
  wire [3:0] new_op;
  wire start;

  assign new_op = i_wdata[3:0];
  assign start = i_wr && (i_addr == `FPS_REG_CTRL) && !busy_reg;

  // ==========================================================
  // data of each bus cycle within an operation
  always @*
  begin
    cyc_data = `FPS_CMD_READ;
    cyc_read = 1'b0;
    case (op_reg)
      `FPS_OP_PROGRAM: cyc_data = (step_reg == 2'h0) ? `FPS_CMD_PROG : wdata_reg[7:0];
      `FPS_OP_ERASE: cyc_data = (step_reg == 2'h0) ? `FPS_CMD_ERASE : `FPS_CMD_CONFIRM;
      `FPS_OP_SUSPEND: cyc_data = (step_reg == 2'h0) ? `FPS_CMD_SUSPEND : `FPS_CMD_STATUS;
      `FPS_OP_RESUME: cyc_data = `FPS_CMD_CONFIRM;
      `FPS_OP_READ_ARRAY: cyc_data = `FPS_CMD_READ;
      `FPS_OP_READ_STATUS: cyc_data = `FPS_CMD_STATUS;
      `FPS_OP_CLEAR: cyc_data = `FPS_CMD_CLEAR;
      `FPS_OP_READ: cyc_read = 1'b1;
      default: cyc_data = `FPS_CMD_READ;
    endcase
    if (step_reg == steps_reg && (op_reg == `FPS_OP_READ_STATUS || op_reg == `FPS_OP_SUSPEND))
    begin
      cyc_read = 1'b1;
    end
  end

  // ==========================================================
  // pin synchroniser
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end
    else
    begin
      dq_s1_reg <= i_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ==========================================================
  // sequencer
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      op_reg <= 4'h0;
      step_reg <= 2'h0;
      steps_reg <= 2'h0;
      rdata_reg <= 16'h0000;
      flash_sr_reg <= 8'h80;
      busy_reg <= 1'b0;
      status_mode_reg <= 1'b0;
      ers_susp_reg <= 1'b0;
      prg_susp_reg <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_flash_addr <= 20'h00000;
      o_dq_out <= 16'h0000;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == `FPS_REG_ADDR)
      begin
        addr_reg <= i_wdata[19:0];
      end
      if (i_wr && i_addr == `FPS_REG_WDATA)
      begin
        wdata_reg <= i_wdata[15:0];
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            op_reg <= new_op;
            step_reg <= 2'h0;
            busy_reg <= 1'b1;
            // two cycle sequences: program, erase, suspend then status read
            steps_reg <= (new_op == `FPS_OP_PROGRAM || new_op == `FPS_OP_ERASE ||
                          new_op == `FPS_OP_SUSPEND || new_op == `FPS_OP_READ_STATUS) ? 2'h1 : 2'h0;
            // erase refused while suspended, program refused on supply error
            if ((new_op == `FPS_OP_ERASE && (ers_susp_reg || flash_sr_reg[`FPS_SR_SUPPLY] ||
                 flash_sr_reg[`FPS_SR_LOCKED])) ||
                (new_op == `FPS_OP_PROGRAM && flash_sr_reg[`FPS_SR_SUPPLY]))
            begin
              busy_reg <= 1'b0;
            end
            else
            begin
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_NEXT:
        begin
          cnt_reg <= `FPS_T_SETUP;
          o_ce_n <= 1'b0;
          o_flash_addr <= addr_reg;
          if (cyc_read)
          begin
            state_reg <= ST_RSETUP;
            o_dq_oe <= 1'b0;
          end
          else
          begin
            state_reg <= ST_WSETUP;
            o_dq_oe <= 1'b1;
            o_dq_out <= (op_reg == `FPS_OP_PROGRAM && step_reg == 2'h1) ? wdata_reg : {8'h00, cyc_data};
          end
        end
        ST_WSETUP:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            o_we_n <= 1'b0;
            cnt_reg <= `FPS_T_STROBE;
            state_reg <= ST_WSTROBE;
          end
        end
        ST_WSTROBE:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            o_we_n <= 1'b1;
            cnt_reg <= `FPS_T_HOLD;
            state_reg <= ST_WHOLD;
          end
        end
        ST_RSETUP:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            o_oe_n <= 1'b0;
            cnt_reg <= `FPS_T_STROBE;
            state_reg <= ST_RSTROBE;
          end
        end
        ST_RSTROBE:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            rdata_reg <= dq_s2_reg;
            if (status_mode_reg || cyc_read && op_reg != `FPS_OP_READ)
            begin
              flash_sr_reg <= dq_s2_reg[7:0];
              ers_susp_reg <= dq_s2_reg[`FPS_SR_ERS_SUSP];
              prg_susp_reg <= dq_s2_reg[`FPS_SR_PRG_SUSP];
            end
            o_oe_n <= 1'b1;
            cnt_reg <= `FPS_T_HOLD;
            state_reg <= ST_RHOLD;
          end
        end
        default:
        begin
          // hold time, then release chip select so the next read refreshes status
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            o_ce_n <= 1'b1;
            o_dq_oe <= 1'b0;
            if (step_reg == steps_reg)
            begin
              state_reg <= ST_IDLE;
              busy_reg <= 1'b0;
              if (op_reg == `FPS_OP_PROGRAM || op_reg == `FPS_OP_ERASE || op_reg == `FPS_OP_READ_STATUS ||
                  op_reg == `FPS_OP_SUSPEND)
              begin
                status_mode_reg <= 1'b1;
              end
              if (op_reg == `FPS_OP_READ_ARRAY)
              begin
                status_mode_reg <= 1'b0;
              end
              if (op_reg == `FPS_OP_RESUME)
              begin
                ers_susp_reg <= 1'b0;
                prg_susp_reg <= 1'b0;
                status_mode_reg <= 1'b1;
              end
            end
            else
            begin
              step_reg <= step_reg + 2'h1;
              state_reg <= ST_NEXT;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // register read port
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rdata <= 32'h00000000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `FPS_REG_CTRL: o_rdata <= {28'h0000000, op_reg};
        `FPS_REG_ADDR: o_rdata <= {12'h000, addr_reg};
        `FPS_REG_WDATA: o_rdata <= {16'h0000, wdata_reg};
        // ready, suspend states and error summary from the last status read
        `FPS_REG_STATUS: o_rdata <= {24'h000000, flash_sr_reg[`FPS_SR_READY], ers_susp_reg, prg_susp_reg,
                                     flash_sr_reg[`FPS_SR_ERS_FAIL] & flash_sr_reg[`FPS_SR_PRG_FAIL],
                                     flash_sr_reg[`FPS_SR_SUPPLY] | flash_sr_reg[`FPS_SR_LOCKED],
                                     flash_sr_reg[`FPS_SR_PRG_FAIL] | flash_sr_reg[`FPS_SR_ERS_FAIL],
                                     status_mode_reg, busy_reg};
        `FPS_REG_RDATA: o_rdata <= {16'h0000, rdata_reg};
        `FPS_REG_FLASH_SR: o_rdata <= {24'h000000, flash_sr_reg};
        default: o_rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire
